// ===== hdl/bc_rt_config_status_regs.sv
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module bc_rt_config_status_regs
  import bc_rt_regs_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,

  // Wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,

  // Controller engine state
  input wire logic bcOnline,
  input wire logic [1:0] retryCount,
  input wire logic badMessage,
  input wire logic msgStatusSet,
  input wire logic goodBlock,
  input wire logic formatError,
  input wire logic noResponse,
  input wire logic [7:0] engineFlagSet,
  input wire logic [7:0] engineFlagClear,

  // Self-test state
  input wire logic protoTestDone,
  input wire logic protoTestBusy,
  input wire logic protoTestPass,
  input wire logic protoTestAbort,
  input wire logic ramTestDone,
  input wire logic ramTestBusy,
  input wire logic ramTestPass,

  // Interrupt sources, one-cycle pulses
  input wire logic opcodeParityError,
  input wire logic illegalCommand,
  input wire logic queueRollover,
  input wire logic callStackError,
  input wire logic trapOpcode,
  input wire logic rtCmdStackHalf,
  input wire logic rtCircBufHalf,
  input wire logic monCmdStackHalf,
  input wire logic monDataStackHalf,
  input wire logic userEventZero,
  input wire logic userEventOne,
  input wire logic userEventTwo,
  input wire logic userEventThree,

  // Configuration, flag and interrupt outputs
  output logic [5:0] memBaseAddr,
  output logic rtHaltEnable,
  output logic responseTimeSelect,
  output logic timeTagSyncEnable,
  output logic watchdogEnable,
  output logic modeCodeResetSelect,
  output logic [7:0] gpFlags,
  output logic irq
);

  typedef struct packed {
    busPhase_e phase;
    logic [15:0] rdData;
    logic [15:0] cfg7;
    logic [15:0] mask2;
    logic testDonePrev;
  } regState_s;

  regState_s st;
  regState_s next_st;

  logic [IDX_W-1:0] idx;
  logic req;
  logic wrReq;
  logic rdReq;
  logic [15:0] lanes;
  logic [15:0] wrData;
  logic [7:0] hostSet;
  logic [7:0] hostClear;
  logic [7:0] flags;
  logic statusClear;
  logic [15:0] events;
  logic [15:0] intStatus;
  logic irqLevel;
  logic testDoneNow;
  logic [15:0] condValue;
  logic [15:0] selfTestValue;
  logic [15:0] readValue;

  // Bus decode
  assign idx = adr_i[ADR_W-1:2];
  assign req = cyc_i & stb_i & (st.phase == PH_IDLE);
  assign wrReq = req & we_i;
  assign rdReq = req & ~we_i;
  assign lanes = laneMask(sel_i[1:0]);
  assign wrData = dat_i[15:0] & lanes;

  // Flag port: low byte sets, high byte clears
  always_comb begin
    hostSet = 8'h00;
    hostClear = 8'h00;
    if (wrReq && idx == IDX_FLAG_CONDITION) begin
      hostSet = wrData[FLAG_SET_HI:FLAG_SET_LO];
      hostClear = wrData[FLAG_CLR_HI:FLAG_CLR_LO];
    end
  end

  gp_flag_bank u_flags (
    .clock(clock),
    .sys_rst(sys_rst),
    .hostSet(hostSet),
    .hostClear(hostClear),
    .engineSet(engineFlagSet),
    .engineClear(engineFlagClear),
    .flags(flags)
  );

  // Either self-test finishing raises the completion event, if the other is not already done
  assign testDoneNow = protoTestDone | ramTestDone;

  always_comb begin
    events = 16'h0000;
    events[INT_PARITY] = opcodeParityError;
    events[INT_ILLEGAL] = illegalCommand;
    events[INT_QUEUE] = queueRollover;
    events[INT_CALL_STACK] = callStackError;
    events[INT_TRAP] = trapOpcode;
    events[INT_RT_CMD_HALF] = rtCmdStackHalf;
    events[INT_RT_CIRC_HALF] = rtCircBufHalf;
    events[INT_MON_CMD_HALF] = monCmdStackHalf;
    events[INT_MON_DATA_HALF] = monDataStackHalf;
    events[INT_USER_HI:INT_USER_LO] = {
      userEventThree,
      userEventTwo,
      userEventOne,
      userEventZero
    };
    events[INT_TEST_DONE] = testDoneNow & ~st.testDonePrev;
  end

  // Writing ones to the status address clears those bits
  assign statusClear = wrReq & (idx == IDX_INT_STATUS_TWO);

  irq_event_latch u_events (
    .clock(clock),
    .sys_rst(sys_rst),
    .events(events),
    .clearWrite(statusClear),
    .clearBits(wrData),
    .mask(st.mask2),
    .status(intStatus),
    .irqOut(irqLevel)
  );

  // Condition register, forced to zero while offline
  always_comb begin
    condValue = COND_OFFLINE;
    if (bcOnline) begin
      condValue[COND_ONE] = 1'b1;
      condValue[COND_RETRY_HI:COND_RETRY_LO] = retryCount;
      condValue[COND_BAD] = badMessage;
      condValue[COND_STATUS_SET] = msgStatusSet;
      condValue[COND_GOOD_BLOCK] = goodBlock;
      condValue[COND_FORMAT] = formatError;
      condValue[COND_NO_RESP] = noResponse;
      // Flags 1 and 0 double as equal and less-than
      condValue[COND_FLAGS_HI:COND_FLAGS_LO] = flags;
    end
  end

  // Self-test status; unlisted bits stay zero
  always_comb begin
    selfTestValue = 16'h0000;
    selfTestValue[ST_PROTO_DONE] = protoTestDone;
    selfTestValue[ST_PROTO_BUSY] = protoTestBusy;
    selfTestValue[ST_PROTO_PASS] = protoTestPass;
    selfTestValue[ST_PROTO_ABORT] = protoTestAbort;
    selfTestValue[ST_PROTO_ACTIVE] = protoTestDone | protoTestBusy;
    selfTestValue[ST_RAM_DONE] = ramTestDone;
    selfTestValue[ST_RAM_BUSY] = ramTestBusy;
    selfTestValue[ST_RAM_PASS] = ramTestPass;
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    readValue = 16'h0000;
    case (idx)
      IDX_CONFIG_SEVEN: begin
        readValue = st.cfg7 & CFG7_WRITABLE;
      end
      IDX_FLAG_CONDITION: begin
        readValue = condValue;
      end
      IDX_SELF_TEST: begin
        readValue = selfTestValue;
      end
      IDX_INT_MASK_TWO: begin
        readValue = st.mask2 & INT2_USED;
      end
      IDX_INT_STATUS_TWO: begin
        readValue = intStatus & INT2_USED;
        readValue[INT_MASTER] = irqLevel;
      end
      default: begin
        readValue = 16'h0000;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.testDonePrev = testDoneNow;
    case (st.phase)
      PH_IDLE: begin
        if (req) begin
          next_st.phase = PH_ACK;
        end
      end
      PH_ACK: begin
        next_st.phase = PH_IDLE;
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
    next_st.rdData = rdReq ? readValue : 16'h0000;
    if (wrReq && idx == IDX_CONFIG_SEVEN) begin
      // Reserved bits 9:5 are never stored
      next_st.cfg7 = laneMerge(st.cfg7, dat_i[15:0], sel_i[1:0])
        & CFG7_WRITABLE;
    end
    if (wrReq && idx == IDX_INT_MASK_TWO) begin
      next_st.mask2 = laneMerge(st.mask2, dat_i[15:0], sel_i[1:0])
        & INT2_USED;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '{
        phase: PH_IDLE,
        rdData: 16'h0000,
        cfg7: CFG7_RESET,
        mask2: MASK2_RESET,
        testDonePrev: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // Bus outputs
  assign ack_o = (st.phase == PH_ACK);
  assign dat_o = {16'h0000, st.rdData};

  // Configuration fields
  assign memBaseAddr = st.cfg7[CFG7_BASE_HI:CFG7_BASE_LO];
  assign rtHaltEnable = st.cfg7[CFG7_RT_HALT];
  assign responseTimeSelect = st.cfg7[CFG7_RESP_TIME];
  assign timeTagSyncEnable = st.cfg7[CFG7_TT_SYNC];
  assign watchdogEnable = st.cfg7[CFG7_WATCHDOG];
  assign modeCodeResetSelect = st.cfg7[CFG7_MC_RESET];
  assign gpFlags = flags;
  assign irq = irqLevel;

endmodule : bc_rt_config_status_regs

// ===== hdl/bc_rt_regs_pkg.sv
package bc_rt_regs_pkg;

  localparam int ADR_W = 8;
  localparam int IDX_W = 6;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONFIG_SEVEN = 6'h19;
  localparam logic [IDX_W-1:0] IDX_FLAG_CONDITION = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_SELF_TEST = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_INT_MASK_TWO = 6'h1d;
  localparam logic [IDX_W-1:0] IDX_INT_STATUS_TWO = 6'h1e;

  // Seventh configuration register
  localparam logic [15:0] CFG7_RESET = 16'h0000;
  localparam logic [15:0] CFG7_WRITABLE = 16'hfc1f;
  localparam int CFG7_BASE_HI = 15;
  localparam int CFG7_BASE_LO = 10;
  localparam int CFG7_RT_HALT = 4;
  localparam int CFG7_RESP_TIME = 3;
  localparam int CFG7_TT_SYNC = 2;
  localparam int CFG7_WATCHDOG = 1;
  localparam int CFG7_MC_RESET = 0;

  // Flag port and condition register
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam int FLAG_SET_HI = 7;
  localparam int FLAG_SET_LO = 0;
  localparam int FLAG_CLR_HI = 15;
  localparam int FLAG_CLR_LO = 8;
  localparam logic [15:0] COND_OFFLINE = 16'h0000;
  localparam int COND_ONE = 15;
  localparam int COND_RETRY_HI = 14;
  localparam int COND_RETRY_LO = 13;
  localparam int COND_BAD = 12;
  localparam int COND_STATUS_SET = 11;
  localparam int COND_GOOD_BLOCK = 10;
  localparam int COND_FORMAT = 9;
  localparam int COND_NO_RESP = 8;
  localparam int COND_FLAGS_HI = 7;
  localparam int COND_FLAGS_LO = 0;

  // Self-test status register
  localparam int ST_PROTO_DONE = 15;
  localparam int ST_PROTO_BUSY = 14;
  localparam int ST_PROTO_PASS = 13;
  localparam int ST_PROTO_ABORT = 12;
  localparam int ST_PROTO_ACTIVE = 11;
  localparam int ST_RAM_DONE = 7;
  localparam int ST_RAM_BUSY = 6;
  localparam int ST_RAM_PASS = 5;

  // Second interrupt mask and status layout
  localparam logic [15:0] MASK2_RESET = 16'h0000;
  localparam logic [15:0] INT2_RESET = 16'h0000;
  localparam logic [15:0] INT2_USED = 16'h7ffe;
  localparam int INT_MASTER = 15;
  localparam int INT_PARITY = 14;
  localparam int INT_ILLEGAL = 13;
  localparam int INT_QUEUE = 12;
  localparam int INT_CALL_STACK = 11;
  localparam int INT_TRAP = 10;
  localparam int INT_RT_CMD_HALF = 9;
  localparam int INT_RT_CIRC_HALF = 8;
  localparam int INT_MON_CMD_HALF = 7;
  localparam int INT_MON_DATA_HALF = 6;
  localparam int INT_USER_HI = 5;
  localparam int INT_USER_LO = 2;
  localparam int INT_TEST_DONE = 1;

  typedef enum logic {PH_IDLE, PH_ACK} busPhase_e;

  function automatic logic [15:0] laneMask(input logic [1:0] sel);
    laneMask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction : laneMask

  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [15:0] wr,
    input logic [1:0] sel
  );
    logic [15:0] m;
    m = laneMask(sel);
    laneMerge = (old & ~m) | (wr & m);
  endfunction : laneMerge

endpackage : bc_rt_regs_pkg

// ===== hdl/gp_flag_bank.sv
`timescale 1ns/10ps
module gp_flag_bank
  import bc_rt_regs_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] hostSet,
  input wire logic [7:0] hostClear,
  input wire logic [7:0] engineSet,
  input wire logic [7:0] engineClear,
  output logic [7:0] flags
);

  typedef struct packed {
    logic [7:0] flags;
  } flagState_s;

  flagState_s st;
  flagState_s next_st;

  always_comb begin
    next_st = st;
    // Any set beats any clear of the same flag
    next_st.flags = (st.flags & ~(hostClear | engineClear))
      | hostSet | engineSet;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '{flags: FLAGS_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

endmodule : gp_flag_bank

// ===== hdl/irq_event_latch.sv
`timescale 1ns/10ps
module irq_event_latch
  import bc_rt_regs_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] events,
  input wire logic clearWrite,
  input wire logic [15:0] clearBits,
  input wire logic [15:0] mask,
  output logic [15:0] status,
  output logic irqOut
);

  typedef struct packed {
    logic [15:0] status;
    logic irq;
  } latchState_s;

  latchState_s st;
  latchState_s next_st;
  logic [15:0] clearNow;

  always_comb begin
    next_st = st;
    clearNow = clearWrite ? clearBits : 16'h0000;
    // Event in the clear cycle survives
    next_st.status = ((st.status & ~clearNow) | events) & INT2_USED;
    // Masked events stay recorded but cannot raise the output
    next_st.irq = |(next_st.status & mask);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st <= '{status: INT2_RESET, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign status = st.status;
  assign irqOut = st.irq;

endmodule : irq_event_latch

// ===== verif/host_master.sv
`timescale 1ns/10ps
module host_master
  import bc_rt_regs_pkg::*;
(
  input wire logic clock,
  input wire logic ackIn,
  output logic cyc = 1'h0,
  output logic stb = 1'h0,
  output logic we = 1'h0,
  output logic [ADR_W-1:0] adr = 8'h00,
  output logic [3:0] sel = 4'h0,
  output logic [31:0] dat = 32'h0
);
  // Request held until ack is sampled; data inverted once released
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [1:0] s, input logic [15:0] d);
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= {2'h0, s};
    dat <= {16'h0, d};
    do @(posedge clock); while (ackIn !== 1'h1);
    cyc <= 1'h0;
    stb <= 1'h0;
    dat <= ~dat;
  endtask : xfer
endmodule : host_master

// ===== verif/bc_rt_regs_asserts.sv
`timescale 1ns/10ps
module bc_rt_regs_asserts
  import bc_rt_regs_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic bcOnline,
  input wire logic [7:0] engineFlagSet,
  input wire logic [5:0] memBaseAddr,
  input wire logic rtHaltEnable,
  input wire logic responseTimeSelect,
  input wire logic timeTagSyncEnable,
  input wire logic watchdogEnable,
  input wire logic modeCodeResetSelect,
  input wire logic [7:0] gpFlags,
  input wire logic irq
);
  logic req;
  logic wr;
  logic rd;
  logic [7:0] setMask;
  logic [7:0] clrMask;
  assign req = cyc_i & stb_i & !ack_o;
  assign wr = req & we_i;
  assign rd = req & !we_i;
  // Flags that a flag port write must set or clear
  always_ff @(posedge clock) begin
    setMask <= dat_i[7:0];
    clrMask <= dat_i[15:8] & ~dat_i[7:0] & ~engineFlagSet;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ack_next_a: assert property (req |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack long");
  base_wr_a: assert property (wr && adr_i == 8'h64 && sel_i[1]
    |=> memBaseAddr == $past(dat_i[15:10])) else $error("base");
  cfg_low_a: assert property (wr && adr_i == 8'h64 && sel_i[0]
    |=> {rtHaltEnable, responseTimeSelect, timeTagSyncEnable, watchdogEnable,
    modeCodeResetSelect} == $past(dat_i[4:0])) else $error("cfg low");
  flag_set_a: assert property (wr && adr_i == 8'h6c && sel_i[0]
    |=> (gpFlags & setMask) == setMask) else $error("flag set");
  flag_clr_a: assert property (wr && adr_i == 8'h6c && sel_i[1:0] == 2'h3
    |=> (gpFlags & clrMask) == 8'h0) else $error("flag clear");
  cond_off_a: assert property (rd && adr_i == 8'h6c && !bcOnline
    |=> dat_o[15:0] == 16'h0) else $error("cond off");
  cond_on_a: assert property (rd && adr_i == 8'h6c && bcOnline
    |=> dat_o[15] && dat_o[7:0] == $past(gpFlags)) else $error("cond");
  test_zero_a: assert property (rd && adr_i == 8'h70
    |=> dat_o[10:8] == 3'h0 && dat_o[4:0] == 5'h0) else $error("st zero");
  mask_off_a: assert property (wr && adr_i == 8'h74 && dat_i[15:0] == 16'h0
    && sel_i[1:0] == 2'h3 |-> ##2 !irq) else $error("masked irq");
  cover property (wr && adr_i == 8'h6c);
  cover property (rd && adr_i == 8'h70);
  cover property ($rose(irq));
endmodule : bc_rt_regs_asserts

bind bc_rt_config_status_regs bc_rt_regs_asserts bc_rt_regs_asserts_inst (
  .clock, .sys_rst, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
  .dat_o, .ack_o, .bcOnline, .engineFlagSet, .memBaseAddr, .rtHaltEnable,
  .responseTimeSelect, .timeTagSyncEnable, .watchdogEnable,
  .modeCodeResetSelect, .gpFlags, .irq
);

// ===== verif/bc_rt_config_status_regs_tb.sv
`timescale 1ns/10ps
module bc_rt_config_status_regs_tb
  import bc_rt_regs_pkg::*;
;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  logic cyc, stb, we, ack, irq;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, datOut;
  logic online = 1'h0;
  logic [6:0] cn = 7'h0;
  logic [6:0] st = 7'h0;
  logic [7:0] efs = 8'h0;
  logic [15:0] ev = 16'h0;
  logic [15:0] expQ[$];
  int n_errors = 0;
  int checks = 0;
  always #25 clock = ~clock;
  host_master host_master_inst (.clock(clock), .ackIn(ack), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat));
  bc_rt_config_status_regs bc_rt_config_status_regs_inst (
    .clock(clock), .sys_rst(sys_rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datOut), .ack_o(ack),
    .bcOnline(online), .retryCount(cn[6:5]), .badMessage(cn[4]),
    .msgStatusSet(cn[3]), .goodBlock(cn[2]), .formatError(cn[1]),
    .noResponse(cn[0]), .engineFlagSet(efs), .engineFlagClear(8'h00),
    .protoTestDone(st[6]), .protoTestBusy(st[5]), .protoTestPass(st[4]),
    .protoTestAbort(st[3]), .ramTestDone(st[2]), .ramTestBusy(st[1]),
    .ramTestPass(st[0]), .opcodeParityError(ev[14]),
    .illegalCommand(ev[13]), .queueRollover(ev[12]),
    .callStackError(ev[11]), .trapOpcode(ev[10]), .rtCmdStackHalf(ev[9]),
    .rtCircBufHalf(ev[8]), .monCmdStackHalf(ev[7]),
    .monDataStackHalf(ev[6]), .userEventZero(ev[2]), .userEventOne(ev[3]),
    .userEventTwo(ev[4]), .userEventThree(ev[5]), .memBaseAddr(),
    .rtHaltEnable(), .responseTimeSelect(), .timeTagSyncEnable(),
    .watchdogEnable(), .modeCodeResetSelect(), .gpFlags(), .irq(irq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host_master_inst.xfer(1'h1, a, 2'h3, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host_master_inst.xfer(1'h0, a, 2'h3, 16'h0);
  endtask : rd
  // Read results matched against notes in order
  always @(posedge clock) begin
    if (ack === 1'h1 && we === 1'h0) begin
      chk(datOut[15:0], expQ.pop_front());
    end
  end
  task automatic print_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    logic [15:0] v;
    void'($urandom(32'hc8ef));
    repeat (16) @(posedge clock);
    sys_rst <= 1'h0;
    rd(8'h64, 16'h0);
    rd(8'h74, 16'h0);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wr(8'h64, v);
      rd(8'h64, v & 16'hfc1f);
    end
    host_master_inst.xfer(1'h1, 8'h64, 2'h1, 16'hffff);
    rd(8'h64, {v[15:10], 10'h1f});
    $display("config test done");
    online <= 1'h1;
    cn <= 7'($urandom);
    wr(8'h6c, 16'h00a5);
    wr(8'h6c, 16'h8102);
    efs <= 8'h10;
    @(posedge clock);
    efs <= 8'h00;
    rd(8'h6c, {1'h1, cn, 8'h36});
    wr(8'h6c, 16'hff00);
    rd(8'h6c, {1'h1, cn, 8'h00});
    online <= 1'h0;
    rd(8'h6c, 16'h0);
    $display("flag test done");
    for (int i = 0; i < 6; i++) begin
      st <= 7'($urandom);
      @(posedge clock);
      rd(8'h70, {st[6:3], st[6] | st[5], 3'h0, st[2:0], 5'h0});
    end
    wr(8'h70, 16'hffff);
    rd(8'h70, {st[6:3], st[6] | st[5], 3'h0, st[2:0], 5'h0});
    wr(8'h40, 16'hffff);
    rd(8'h40, 16'h0);
    $display("self-test done");
    st <= 7'h0;
    wr(8'h78, 16'hffff);
    wr(8'h74, 16'hffff);
    rd(8'h74, 16'h7ffe);
    wr(8'h74, 16'h0);
    ev <= 16'h7ffc;
    st <= 7'h40;
    @(posedge clock);
    ev <= 16'h0;
    rd(8'h78, 16'h7ffe);
    chk({15'h0, irq}, 16'h0);
    wr(8'h74, 16'h03c0);
    rd(8'h78, 16'hfffe);
    chk({15'h0, irq}, 16'h1);
    wr(8'h74, 16'h0);
    @(posedge clock);
    chk({15'h0, irq}, 16'h0);
    wr(8'h74, 16'h03c0);
    rd(8'h78, 16'hfffe);
    wr(8'h78, 16'h03c0);
    rd(8'h78, 16'h7c3e);
    wr(8'h78, 16'hffff);
    rd(8'h78, 16'h0);
    $display("interrupt test done");
    repeat (2) @(posedge clock);
    print_verdict();
  end
  initial begin
    #(50 * 4000);
    n_errors++;
    print_verdict();
  end
endmodule : bc_rt_config_status_regs_tb
